// ---- tcs_regs.svh ----
// register pointers, field positions, reset values and timing figures
// assumes: included by bare name from each design file that needs it
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

`define TCS_PTR_STATUS   8'h08
`define TCS_PTR_CFG1     8'h09
`define TCS_PTR_CFG2     8'h0A
`define TCS_PTR_RATE     8'h0B
`define TCS_PTR_ONESHOT  8'h0F

`define TCS_BIT_BUSY     7
`define TCS_BIT_HALT     6
`define TCS_BIT_RC       2
`define TCS_BIT_LOCAL    3
`define TCS_BIT_REM1     4
`define TCS_BIT_REM2     5
`define TCS_BIT_REM3     6
`define TCS_RATE_MSB     2

`define TCS_CFG1_POR     8'h00
`define TCS_CFG1_WMASK   8'h44
`define TCS_CFG2_POR1    8'h1C
`define TCS_CFG2_REM2    8'h20
`define TCS_CFG2_REM3    8'h40
`define TCS_RATE_POR     8'h07
`define TCS_RATE_WMASK   8'h07

`define TCS_CONV_TIME_MS 125
`define TCS_SLOW_PER_S   16
`define TCS_CLK_MHZ      100
`define TCS_US_PER_MS    1000
`define TCS_US_PER_S     1000000
`define TCS_BYTE_BITS    4'h8
`define TCS_DEV_ADDR     7'h4C

`endif

// ---- tcs_pkg.sv ----
// types shared by the sequencer and its serial register port
// assumes: nothing beyond a SystemVerilog compiler
package tcs_pkg;

  typedef enum logic [2:0] {
    SEQ_KICK = 3'b000,
    SEQ_CONV = 3'b001,
    SEQ_SHUT = 3'b010,
    SEQ_WAIT = 3'b011,
    SEQ_IDLE = 3'b100
  } tcs_seq_t;

  typedef enum logic [3:0] {
    LNK_IDLE = 4'b0000,
    LNK_ADDR = 4'b0001,
    LNK_AACK = 4'b0010,
    LNK_PTR  = 4'b0011,
    LNK_PACK = 4'b0100,
    LNK_WDAT = 4'b0101,
    LNK_DACK = 4'b0110,
    LNK_RDAT = 4'b0111,
    LNK_RACK = 4'b1000
  } tcs_lnk_t;

  typedef struct packed {
    tcs_seq_t    st;
    logic [1:0]  chan;
    logic        single;
    logic        busy;
    logic [31:0] conv_cnt;
    logic [31:0] pass_cnt;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  rate;
    logic [7:0]  rd_data;
  } tcs_seq_state_t;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    tcs_lnk_t   st;
    logic [3:0] bitc;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       rw;
    logic       mack;
    logic       sda_oe;
    logic       wr_stb;
    logic [7:0] wr_data;
  } tcs_lnk_state_t;

endpackage

// ---- tcs_link.sv ----
// two-wire serial register port: address, pointer, byte writes and reads
// assumes: scl/sda come from pins; sda wire is resolved outside from oe
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"

module tcs_link #(
  parameter logic [6:0] DEV_ADDR = `TCS_DEV_ADDR
) (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            wr_stb_out,
  output logic [7:0]      wr_data_out,
  output logic [7:0]      ptr_out,
  input  wire logic [7:0] rd_data_in
);

  tcs_pkg::tcs_lnk_state_t s_r;
  tcs_pkg::tcs_lnk_state_t s_nxt;

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    s_nxt = s_r;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    s_nxt.scl_s1 = scl_in;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_d = s_r.scl_s2;
    s_nxt.sda_s1 = sda_in;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_d = s_r.sda_s2;
    s_nxt.wr_stb = 1'b0;
    rise = s_r.scl_s2 & ~s_r.scl_d;
    fall = ~s_r.scl_s2 & s_r.scl_d;
    start = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
    stop = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
    if (start) begin
      s_nxt.st = tcs_pkg::LNK_ADDR;
      s_nxt.bitc = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      s_nxt.st = tcs_pkg::LNK_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        tcs_pkg::LNK_IDLE: begin
          s_nxt.sda_oe = 1'b0;
        end
        tcs_pkg::LNK_ADDR, tcs_pkg::LNK_PTR, tcs_pkg::LNK_WDAT: begin
          if (rise && s_r.bitc != `TCS_BYTE_BITS) begin
            s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s2};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (fall && s_r.bitc == `TCS_BYTE_BITS) begin
            s_nxt.bitc = 4'h0;
            s_nxt.sda_oe = 1'b1;
            if (s_r.st == tcs_pkg::LNK_ADDR) begin
              s_nxt.rw = s_r.shreg[0];
              if (s_r.shreg[7:1] == DEV_ADDR) begin
                s_nxt.st = tcs_pkg::LNK_AACK;
              end else begin
                s_nxt.st = tcs_pkg::LNK_IDLE;
                s_nxt.sda_oe = 1'b0;
              end
            end else if (s_r.st == tcs_pkg::LNK_PTR) begin
              s_nxt.ptr = s_r.shreg;
              s_nxt.st = tcs_pkg::LNK_PACK;
            end else begin
              s_nxt.wr_data = s_r.shreg;
              s_nxt.wr_stb = 1'b1;
              s_nxt.st = tcs_pkg::LNK_DACK;
            end
          end
        end
        tcs_pkg::LNK_AACK: begin
          if (fall && s_r.rw) begin
            s_nxt.shreg = rd_data_in;
            s_nxt.sda_oe = ~rd_data_in[7];
            s_nxt.bitc = 4'h1;
            s_nxt.st = tcs_pkg::LNK_RDAT;
          end else if (fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = tcs_pkg::LNK_PTR;
          end
        end
        tcs_pkg::LNK_PACK, tcs_pkg::LNK_DACK: begin
          if (fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = tcs_pkg::LNK_WDAT;
          end
        end
        tcs_pkg::LNK_RDAT: begin
          if (fall && s_r.bitc == `TCS_BYTE_BITS) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = tcs_pkg::LNK_RACK;
          end else if (fall) begin
            s_nxt.sda_oe = ~s_r.shreg[6];
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end
        end
        tcs_pkg::LNK_RACK: begin
          if (rise) begin
            s_nxt.mack = ~s_r.sda_s2;
          end else if (fall && s_r.mack) begin
            s_nxt.shreg = rd_data_in;
            s_nxt.sda_oe = ~rd_data_in[7];
            s_nxt.bitc = 4'h1;
            s_nxt.st = tcs_pkg::LNK_RDAT;
          end else if (fall) begin
            s_nxt.st = tcs_pkg::LNK_IDLE;
          end
        end
        default: begin
          s_nxt.st = tcs_pkg::LNK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r <= '{st: tcs_pkg::LNK_IDLE, scl_s1: 1'b1, scl_s2: 1'b1,
               scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out     = 1'b0;
  assign sda_oe_out  = s_r.sda_oe;
  assign wr_stb_out  = s_r.wr_stb;
  assign wr_data_out = s_r.wr_data;
  assign ptr_out     = s_r.ptr;

endmodule
`default_nettype wire

// ---- tcs_sequencer.sv ----
// temperature channel sequencer with its configuration and rate registers
// assumes: host reaches registers over the two-wire pins; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"

module tcs_sequencer #(
  parameter int          NUM_REMOTE     = 3,
  parameter logic [31:0] CONV_CYCLES    = 32'(`TCS_CONV_TIME_MS *
                                          `TCS_US_PER_MS * `TCS_CLK_MHZ),
  parameter logic [31:0] PERIOD0_CYCLES = 32'(longint'(`TCS_SLOW_PER_S) *
                                          `TCS_US_PER_S * `TCS_CLK_MHZ),
  parameter logic [6:0]  DEV_ADDR       = `TCS_DEV_ADDR
) (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            busy_out,
  output logic [1:0]      chan_out,
  output logic            series_resistance_fix_on_out
);

  localparam logic [7:0] CFG2_POR = `TCS_CFG2_POR1 |
    ((NUM_REMOTE >= 2) ? `TCS_CFG2_REM2 : 8'h00) |
    ((NUM_REMOTE >= 3) ? `TCS_CFG2_REM3 : 8'h00);
  localparam logic [31:0] CONV_HALF = CONV_CYCLES >> 1;

  generate
    if (NUM_REMOTE < 1 || NUM_REMOTE > 3 || CONV_CYCLES < 32'h4) begin : g_bad
      $error("tcs_sequencer: unsupported parameter values");
    end
  endgenerate

  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] ptr;
  logic       oneshot;
  logic       halt;
  logic [3:0] en;
  logic [31:0] period;
  logic [31:0] conv_len;

  tcs_pkg::tcs_seq_state_t s_r;
  tcs_pkg::tcs_seq_state_t s_nxt;

  tcs_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe_out (sda_oe_out),
    .wr_stb_out (wr_stb),
    .wr_data_out(wr_data),
    .ptr_out    (ptr),
    .rd_data_in (s_r.rd_data)
  );

  // first enabled channel at or after 'from'; msb flags found
  function automatic logic [2:0] next_en(input logic [2:0] from,
                                         input logic [3:0] mask);
    logic [2:0] res;
    res = 3'b000;
    for (int i = 3; i >= 0; i--) begin
      if (mask[i] && 3'(i) >= from) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  assign en = {s_r.cfg2[`TCS_BIT_REM3], s_r.cfg2[`TCS_BIT_REM2],
               s_r.cfg2[`TCS_BIT_REM1], s_r.cfg2[`TCS_BIT_LOCAL]};
  assign halt    = s_r.cfg1[`TCS_BIT_HALT];
  assign oneshot = wr_stb && ptr == `TCS_PTR_ONESHOT;
  // rate sets the pass period only
  assign period  = PERIOD0_CYCLES >> s_r.rate[`TCS_RATE_MSB:0];
  assign conv_len = (s_r.chan == 2'b00 || s_r.cfg2[`TCS_BIT_RC]) ?
                    CONV_CYCLES : CONV_HALF;

  always_comb begin
    logic       go;
    logic [2:0] nx;
    s_nxt = s_r;
    go = 1'b0;
    nx = 3'b000;
    // register writes, reserved bits held at zero
    if (wr_stb && ptr == `TCS_PTR_CFG1) begin
      s_nxt.cfg1 = wr_data & `TCS_CFG1_WMASK;
    end
    if (wr_stb && ptr == `TCS_PTR_CFG2) begin
      s_nxt.cfg2 = wr_data & CFG2_POR;
    end
    if (wr_stb && ptr == `TCS_PTR_RATE) begin
      s_nxt.rate = wr_data & `TCS_RATE_WMASK;
    end
    if (s_r.pass_cnt != 32'hFFFF_FFFF) begin
      s_nxt.pass_cnt = s_r.pass_cnt + 32'h1;
    end
    case (s_r.st)
      tcs_pkg::SEQ_KICK: begin
        go = 1'b1;
      end
      tcs_pkg::SEQ_WAIT: begin
        // one-shot cuts the idle delay short
        if (oneshot) begin
          go = 1'b1;
          s_nxt.single = halt;
        end else if (halt) begin
          s_nxt.st = tcs_pkg::SEQ_IDLE;
        end else if (s_r.pass_cnt >= period - 32'h1) begin
          go = 1'b1;
        end
      end
      tcs_pkg::SEQ_IDLE: begin
        // single pass on one-shot while halted
        if (oneshot) begin
          go = 1'b1;
          s_nxt.single = halt;
        end else if (!halt) begin
          go = 1'b1;
        end
      end
      tcs_pkg::SEQ_CONV: begin
        s_nxt.conv_cnt = s_r.conv_cnt + 32'h1;
        if (s_r.conv_cnt >= conv_len - 32'h1) begin
          nx = next_en(3'(s_r.chan) + 3'h1, en);
          s_nxt.conv_cnt = '0;
          if (nx[2]) begin
            s_nxt.chan = nx[1:0];
          end else begin
            s_nxt.st = tcs_pkg::SEQ_SHUT;
          end
        end
      end
      tcs_pkg::SEQ_SHUT: begin
        // halt takes effect only once the pass is done
        if (halt || s_r.single) begin
          s_nxt.st = tcs_pkg::SEQ_IDLE;
          s_nxt.single = 1'b0;
        end else begin
          s_nxt.st = tcs_pkg::SEQ_WAIT;
        end
      end
      default: begin
        s_nxt.st = tcs_pkg::SEQ_IDLE;
      end
    endcase
    if (go) begin
      nx = next_en(3'h0, en);
      s_nxt.pass_cnt = '0;
      s_nxt.conv_cnt = '0;
      s_nxt.chan = nx[2] ? nx[1:0] : 2'b00;
      s_nxt.st = nx[2] ? tcs_pkg::SEQ_CONV : tcs_pkg::SEQ_SHUT;
    end
    s_nxt.busy = (s_nxt.st == tcs_pkg::SEQ_CONV);
    case (ptr)
      `TCS_PTR_STATUS: s_nxt.rd_data = {s_r.busy, 7'h00};
      `TCS_PTR_CFG1:   s_nxt.rd_data = s_r.cfg1;
      `TCS_PTR_CFG2:   s_nxt.rd_data = s_r.cfg2;
      `TCS_PTR_RATE:   s_nxt.rd_data = s_r.rate;
      default:         s_nxt.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r <= '{st: tcs_pkg::SEQ_KICK, cfg1: `TCS_CFG1_POR,
               cfg2: CFG2_POR, rate: `TCS_RATE_POR, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_out = s_r.busy;
  assign chan_out = s_r.chan;
  assign series_resistance_fix_on_out = s_r.cfg2[`TCS_BIT_RC];

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_to_idle;
    ##1 (s_r.st == tcs_pkg::SEQ_IDLE);
  endsequence

  sequence s_conv_next;
    ##1 busy_out;
  endsequence

  chk_rate_upper_zero: assert property (s_r.rate[7:3] == 5'h00)
    else $error("rate upper bits not zero");

  chk_cfg2_reserved: assert property (
    s_r.cfg2[7] == 1'b0 && s_r.cfg2[1:0] == 2'b00)
    else $error("cfg2 reserved bits set");

  chk_busy_conv: assert property (
    busy_out == (s_r.st == tcs_pkg::SEQ_CONV))
    else $error("busy flag disagrees with converter");

  chk_skip_disabled: assert property (
    (busy_out && ($rose(busy_out) || $changed(chan_out))) |->
      en[chan_out] || $past(wr_stb))
    else $error("disabled channel converted");

  chk_order_up: assert property (
    ($past(busy_out) && busy_out && $changed(chan_out)) |->
      chan_out > $past(chan_out))
    else $error("channel order broken");

  chk_halt_stops: assert property (
    (s_r.st == tcs_pkg::SEQ_SHUT && halt) |-> s_to_idle)
    else $error("halt did not stop after pass");

  chk_oneshot_go: assert property (
    ((s_r.st == tcs_pkg::SEQ_WAIT || s_r.st == tcs_pkg::SEQ_IDLE) &&
     oneshot && en != 4'h0) |-> s_conv_next)
    else $error("one-shot did not start a pass");

  chk_conv_half: assert property (
    (busy_out && chan_out != 2'b00 && !s_r.cfg2[`TCS_BIT_RC] &&
     !$past(wr_stb)) |-> s_r.conv_cnt < CONV_HALF)
    else $error("uncorrected conversion too long");

  chk_wait_period: assert property (
    (s_r.st == tcs_pkg::SEQ_WAIT && !halt && !oneshot &&
     s_r.pass_cnt < period - 32'h1) |=> (s_r.st == tcs_pkg::SEQ_WAIT))
    else $error("pass restarted before period");

endmodule
`default_nettype wire

// ---- tcs_host.sv ----
// host model driving the two-wire register port
// assumes: sda resolved outside with a pull-up; scl has no other driver
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_host (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  localparam realtime Q = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    sda_oe_out = ~b;
    #Q scl_out = 1'b1;
    #Q s = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_oe_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_oe_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_oe_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_oe_out = 1'b0;
    #(2 * Q);
  endtask
  // byte out msb first, ninth bit released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  function automatic logic [7:0] legal(input logic [7:0] p,
                                       input logic [7:0] d);
    case (p)
      8'h09: return d & 8'h44;
      8'h0A: return d & 8'h7C;
      8'h0B: return d & 8'h07;
      default: return d;
    endcase
  endfunction
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2;
    start();
    xfer({`TCS_DEV_ADDR, 1'b0}, x, a0);
    xfer(p, x, a1);
    xfer(legal(p, d), x, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] q,
                    output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2, a3;
    start();
    xfer({`TCS_DEV_ADDR, 1'b0}, x, a0);
    xfer(p, x, a1);
    start();
    xfer({`TCS_DEV_ADDR, 1'b1}, x, a2);
    xfer(8'hFF, q, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic one_shot(output logic ok);
    wr(8'h0F, 8'h00, ok);
  endtask
endmodule
`default_nettype wire

// ---- tcs_sequencer_tb.sv ----
// self-checking bench for the channel sequencer
// assumes: short conversion and period parameters, host model on pins
`timescale 1ns/1ps
`default_nettype none
module tcs_sequencer_tb;
  localparam int CONV = 40;
  localparam int PER0 = 5120;
  logic       sys_clk;
  logic       sys_rst;
  logic       scl, sda, h_oe, d_oe, d_out, busy, fix_on;
  logic [1:0] chan;
  int         num_errors = 0;
  int         num_checks = 0;
  logic [1:0] seg_ch[$];
  int         seg_len[$];
  realtime    t_start;

  assign sda = ~(h_oe | (d_oe & ~d_out));

  tcs_sequencer #(
    .NUM_REMOTE    (3),
    .CONV_CYCLES   (32'd40),
    .PERIOD0_CYCLES(32'(PER0))
  ) uut (
    .sys_clk_in                  (sys_clk),
    .sys_rst_in                  (sys_rst),
    .scl_in                      (scl),
    .sda_in                      (sda),
    .sda_out                     (d_out),
    .sda_oe_out                  (d_oe),
    .busy_out                    (busy),
    .chan_out                    (chan),
    .series_resistance_fix_on_out(fix_on)
  );
  tcs_host host (
    .sda_in    (sda),
    .scl_out   (scl),
    .sda_oe_out(h_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host.wr(p, d, ok);
    check("wr ack", ok, 1'b1);
    tick();
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    logic       ok;
    logic [7:0] q;
    host.rd(p, q, ok);
    check("rd ack", ok, 1'b1);
    check("rd data", q, e);
    tick();
  endtask
  task automatic shot();
    logic ok;
    host.one_shot(ok);
    check("shot ack", ok, 1'b1);
    tick();
  endtask
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v && n < lim) begin
      tick();
      n++;
    end
  endtask
  task automatic quiet(input int cyc, output int hits);
    hits = 0;
    repeat (cyc) begin
      tick();
      if (busy === 1'b1) hits++;
    end
  endtask
  // record one whole pass: channel and length of each conversion
  task automatic get_pass();
    int n;
    seg_ch.delete();
    seg_len.delete();
    wait_busy(1'b0, 2000);
    wait_busy(1'b1, 6000);
    t_start = $realtime;
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      if (seg_ch.size() == 0 || seg_ch[$] !== chan) begin
        seg_ch.push_back(chan);
        seg_len.push_back(0);
      end
      seg_len[$] = seg_len[$] + 1;
      tick();
      n++;
    end
  endtask
  task automatic check_pass(input logic [3:0] m, input logic rc);
    int k;
    get_pass();
    k = 0;
    for (int c = 0; c < 4; c++) begin
      if (m[c]) begin
        check("chan", seg_ch[k], c);
        check("len", seg_len[k], (c == 0 || rc) ? CONV : CONV / 2);
        k++;
      end
    end
    check("count", seg_ch.size(), k);
  endtask
  task automatic meas(input int lo);
    realtime t1;
    int      iv;
    get_pass();
    t1 = t_start;
    get_pass();
    iv = int'((t_start - t1) / 10.0);
    check("interval", iv >= lo && iv <= lo + 4, 1'b1);
  endtask

  task automatic t_reset();
    check("fix on", fix_on, 1'b1);
    rreg(8'h0A, 8'h7C);
    rreg(8'h0B, 8'h07);
    rreg(8'h0C, 8'h00);
    check_pass(4'hF, 1'b1);
  endtask
  task automatic t_chan();
    logic [7:0] cfg [4] = '{8'h78, 8'h54, 8'h2C, 8'h30};
    foreach (cfg[i]) begin
      wreg(8'h0A, cfg[i]);
      rreg(8'h0A, cfg[i]);
      check("fix on", fix_on, cfg[i][2]);
      check_pass(cfg[i][6:3], cfg[i][2]);
    end
  endtask
  task automatic t_rate();
    int p;
    wreg(8'h0A, 8'h0C);
    for (int c = 7; c >= 0; c--) begin
      wreg(8'h0B, 8'(c));
      rreg(8'h0B, 8'(c));
      p = PER0 >> c;
      meas(p > CONV ? p : CONV);
      check("conv len", seg_len[0], CONV);
    end
  endtask
  task automatic t_oneshot();
    get_pass();
    repeat (100) tick();
    shot();
    wait_busy(1'b1, 20);
    check("shot start", busy, 1'b1);
    wreg(8'h0A, 8'h7C);
    wreg(8'h0B, 8'h07);
    shot();
    meas(4 * CONV);
  endtask
  // conversion time dominating the pass period
  task automatic t_slow();
    wreg(8'h0B, 8'h06);
    wreg(8'h0A, 8'h1C);
    meas(2 * CONV);
    wreg(8'h0A, 8'h3C);
    meas(3 * CONV);
    wreg(8'h0B, 8'h07);
    wreg(8'h0A, 8'h1C);
    meas(2 * CONV);
    wreg(8'h0A, 8'h7C);
  endtask
  task automatic t_halt();
    int h;
    rreg(8'h08, 8'h80);
    wreg(8'h09, 8'h40);
    wait_busy(1'b0, 200);
    quiet(300, h);
    check("halted", h, 0);
    rreg(8'h08, 8'h00);
    // single pass starts inside the write, so record alongside it
    fork
      shot();
      check_pass(4'hF, 1'b1);
    join
    quiet(300, h);
    check("single", h, 0);
    wreg(8'h09, 8'h00);
    wait_busy(1'b1, 20);
    check("resume", busy, 1'b1);
  endtask

  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_chan();
    t_rate();
    t_oneshot();
    t_slow();
    t_halt();
    wrap_up();
  end
endmodule
`default_nettype wire
